// ### hw/rsi_classify.sv
/*
 reset classifier: decodes the reset source bundle into a single reset kind.
 assumes: sources are synchronous to CLK and at most one kind is acted on per cycle.
*/
`timescale 1ns/10ps
module rsi_classify
(
    input wire rsi_pkg::rsi_src_t src,
    output rsi_pkg::rsi_kind_t kind
);
    ////////////////////////////////////////////////////////////////////////////////
    // priority decode: power-on dominates, then low voltage, then watchdog
    always_comb
    begin
        if (src.por)
        begin
            kind = rsi_pkg::RK_POWER_ON;
        end
        else if (src.low_voltage_reset && !src.halted)
        begin
            // low voltage detect is off while halted, so ignore it there
            kind = rsi_pkg::RK_LOW_VOLTAGE;
        end
        else if (src.wdt && src.halted)
        begin
            kind = rsi_pkg::RK_WDT_HALT;
        end
        else if (src.wdt)
        begin
            kind = rsi_pkg::RK_WDT_RUN;
        end
        else
        begin
            kind = rsi_pkg::RK_NONE;
        end
    end
endmodule // rsi_classify

// ### hw/rsi_pkg.sv
/*
 reset initial conditions package: reset kinds, widths, post-reset values and the
 packed structs that carry the reset request and the peripheral init controls.
 assumes: nothing beyond a sv-2012 compiler.
*/
package rsi_pkg;
    // program counter and stack geometry
    localparam int PC_W = 13;
    localparam int SP_W = 3;
    localparam logic [12:0] PC_RST = 13'h0000;
    localparam logic [2:0] SP_TOP = 3'h0;
    // io direction: one means input
    localparam int IO_W = 29;
    localparam logic [28:0] IO_ALL_IN = 29'h1FFFFFFF;
    localparam int TM_N = 3;
    localparam logic [2:0] TM_ALL_OFF = 3'h0;
    localparam logic FLAG_CLR = 1'h0;
    localparam logic FLAG_SET = 1'h1;
    localparam logic [1:0] SEQ_CNT_MAX = 2'h3;

    // kind of reset that was recognised
    typedef enum logic [2:0]
    {
        RK_NONE,
        RK_POWER_ON,
        RK_LOW_VOLTAGE,
        RK_WDT_RUN,
        RK_WDT_HALT
    } rsi_kind_t;

    // reset request from the sources
    typedef struct packed
    {
        logic por;
        logic low_voltage_reset;
        logic wdt;
        logic halted;
    } rsi_src_t;

    // post-reset control bundle to core and peripherals
    typedef struct packed
    {
        logic pc_clear;
        logic sp_load;
        logic int_disable;
        logic wdt_tb_clear;
        logic tm_off;
        logic io_input;
    } rsi_init_t;
endpackage

// ### hw/rsi_reset_init.sv
/*
 reset initial conditions block: keeps the time-out and power-down flags,
 and drives the core and peripherals to their post-reset state.
 assumes: reset sources are synchronous one-cycle-or-longer levels on CLK;
 the core accepts the init pulses and the pc/sp values on the same edge.
 limitation: a request that only stands on cycles with CE low is lost, so
 sources must stand until an enabled edge; the status flags have no
 software clear here, so a set and a clear can never meet in one cycle.
*/
// Functional notes
// - power-on clears both status flags
// - low-voltage reset keeps both flags
// - running watchdog reset sets timeout only
// - halted watchdog reset sets both flags
// - power-on disables every interrupt
// - power-on clears watchdog, time bases; watchdog runs
// - power-on switches all timers off
// - power-on makes all io pins inputs
// - power-on points stack at top
// - power-on forces program counter to zero
`timescale 1ns/10ps
module rsi_reset_init
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic POR_REQ,
    input wire logic LOW_VOLTAGE_RESET,
    input wire logic WDT_TIMEOUT,
    input wire logic HALTED,
    output logic TIMEOUT_FLAG,
    output logic POWER_DOWN_FLAG,
    output logic PC_CLEAR,
    output logic [12:0] PC_VALUE,
    output logic SP_LOAD,
    output logic [2:0] SP_VALUE,
    output logic INT_DISABLE,
    output logic WDT_TB_CLEAR,
    output logic WDT_RUN,
    output logic TM_OFF,
    output logic [2:0] TM_ENABLE_MASK,
    output logic IO_INPUT,
    output logic [28:0] IO_DIR_IN,
    output logic [2:0] RESET_KIND
);
    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    // the decoded kind feeds both next-state processes, so they never disagree
    rsi_pkg::rsi_src_t src; // bundled sources
    rsi_pkg::rsi_kind_t kind; // decoded kind this cycle
    logic timeout_ff; // time-out status flag
    logic nxt_timeout;
    logic pdown_ff; // power-down status flag
    logic nxt_pdown;
    rsi_pkg::rsi_init_t init_ff; // registered one-cycle init controls
    rsi_pkg::rsi_init_t nxt_init;
    rsi_pkg::rsi_kind_t kind_ff; // last reset kind seen
    rsi_pkg::rsi_kind_t nxt_kind;
    logic wdt_run_ff; // watchdog counting permission
    logic nxt_wdt_run;

    // one assignment fills the whole bundle, so it has a single driver
    assign src = {POR_REQ, LOW_VOLTAGE_RESET, WDT_TIMEOUT, HALTED};

    ////////////////////////////////////////////////////////////////////////////////
    // source decode
    // one priority decode shared by the flags and the pulses
    rsi_classify u_classify
    (
        .src (src),
        .kind (kind)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // status flags next state; priority and the halted refusal of the low
    // voltage request live in the classifier, so each branch here sees
    // exactly one kind
    always_comb
    begin
        nxt_timeout = timeout_ff;
        nxt_pdown = pdown_ff;
        unique case (kind)
            rsi_pkg::RK_POWER_ON:
            begin
                nxt_timeout = rsi_pkg::FLAG_CLR;
                nxt_pdown = rsi_pkg::FLAG_CLR;
            end
            rsi_pkg::RK_LOW_VOLTAGE:
            begin
                // both flags hold their previous value
                nxt_timeout = timeout_ff;
                nxt_pdown = pdown_ff;
            end
            rsi_pkg::RK_WDT_RUN:
            begin
                // power-down flag untouched: the core was running
                nxt_timeout = rsi_pkg::FLAG_SET;
            end
            rsi_pkg::RK_WDT_HALT:
            begin
                nxt_timeout = rsi_pkg::FLAG_SET;
                nxt_pdown = rsi_pkg::FLAG_SET;
            end
            rsi_pkg::RK_NONE:
            begin
                // idle: flags stay
            end
            default:
            begin
                // illegal kind code: hold flags
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // init control pulses next state; the pulses are rebuilt every cycle, so
    // a request held for n enabled edges gives n cycles of pulse, one cycle behind
    // the request, so the last pulse stands in the cycle after the sources drop
    always_comb
    begin
        nxt_init = '0;
        nxt_kind = kind_ff;
        nxt_wdt_run = wdt_run_ff;
        unique case (kind)
            rsi_pkg::RK_POWER_ON:
            begin
                nxt_kind = kind;
                nxt_init.pc_clear = 1'h1;
                nxt_init.sp_load = 1'h1;
                nxt_init.int_disable = 1'h1;
                nxt_init.wdt_tb_clear = 1'h1;
                nxt_init.tm_off = 1'h1;
                nxt_init.io_input = 1'h1;
                nxt_wdt_run = 1'h1;
            end
            rsi_pkg::RK_LOW_VOLTAGE, rsi_pkg::RK_WDT_RUN:
            begin
                // running resets act as full resets of the core state; the
                // watchdog keeps its run permission and only restarts its count
                nxt_kind = kind;
                nxt_init.pc_clear = 1'h1;
                nxt_init.sp_load = 1'h1;
                nxt_init.int_disable = 1'h1;
                nxt_init.wdt_tb_clear = 1'h1;
                nxt_init.tm_off = 1'h1;
                nxt_init.io_input = 1'h1;
            end
            rsi_pkg::RK_WDT_HALT:
            begin
                // halted watchdog reset only restarts pc and stack; the rest of
                // the core keeps its state for the code that runs after wake-up
                nxt_kind = kind;
                nxt_init.pc_clear = 1'h1;
                nxt_init.sp_load = 1'h1;
            end
            rsi_pkg::RK_NONE:
            begin
                // no request: pulses low, last kind kept for software
            end
            default:
            begin
                // illegal kind code: no pulse, kind kept
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status flag registers; the block reset acts as a power-on, so both flags
    // clear; the reset wins over a low enable so a stalled enable cannot keep
    // stale flags through a reset
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            timeout_ff <= rsi_pkg::FLAG_CLR;
            pdown_ff <= rsi_pkg::FLAG_CLR;
        end
        else if (CE)
        begin
            timeout_ff <= nxt_timeout;
            pdown_ff <= nxt_pdown;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // init control registers; the pulses stand while RST_N is low so the
    // peripherals start clean, and fall at the first enabled edge after it,
    // unless a source is already asking again
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            init_ff <= '1;
            kind_ff <= rsi_pkg::RK_POWER_ON;
            wdt_run_ff <= 1'h1;
        end
        else if (CE)
        begin
            init_ff <= nxt_init;
            kind_ff <= nxt_kind;
            wdt_run_ff <= nxt_wdt_run;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs, all from flip-flops or constants; the load values are fixed and
    // only the pulses say when they apply, which keeps the pc, stack, timer
    // and io paths free of extra registers
    assign TIMEOUT_FLAG = timeout_ff;
    assign POWER_DOWN_FLAG = pdown_ff;
    // init pulses towards the core and the peripherals
    assign PC_CLEAR = init_ff.pc_clear;
    assign PC_VALUE = rsi_pkg::PC_RST;
    assign SP_LOAD = init_ff.sp_load;
    assign SP_VALUE = rsi_pkg::SP_TOP;
    assign INT_DISABLE = init_ff.int_disable;
    assign WDT_TB_CLEAR = init_ff.wdt_tb_clear;
    assign WDT_RUN = wdt_run_ff;
    assign TM_OFF = init_ff.tm_off;
    assign TM_ENABLE_MASK = rsi_pkg::TM_ALL_OFF;
    assign IO_INPUT = init_ff.io_input;
    assign IO_DIR_IN = rsi_pkg::IO_ALL_IN;
    // last kind seen, so software can tell why it restarted
    assign RESET_KIND = kind_ff;
endmodule // rsi_reset_init

// ### tb/rsi_core_model.sv
/*
 model of the core and peripheral state that the init controls load.
 assumes: the init bundle is sampled on the rising clock edge.
*/
`timescale 1ns/10ps
module rsi_core_model
(
    input wire logic clk,
    input wire rsi_pkg::rsi_init_t init,
    input wire logic [12:0] pc_val,
    input wire logic [2:0] sp_val,
    input wire logic [2:0] tm_val,
    input wire logic [28:0] dir_val,
    input wire logic wdt_run,
    output logic [12:0] pc,
    output logic [2:0] sp,
    output logic [2:0] tm,
    output logic [28:0] dir,
    output logic [3:0] wdt_cnt,
    output logic ien
);
    ////////////////////////////////////////
    // without a pulse the state drifts as running code would move it,
    // so a missing pulse shows as a wrong value one cycle later
    always_ff @(posedge clk)
    begin
        pc <= init.pc_clear ? pc_val : pc + 13'h0001;
        sp <= init.sp_load ? sp_val : sp + 3'h1;
        ien <= !init.int_disable;
        tm <= init.tm_off ? tm_val : 3'h7;
        dir <= init.io_input ? dir_val : 29'h00000000;
        // watchdog count: cleared by its pulse, then counts while allowed to run
        wdt_cnt <= init.wdt_tb_clear ? 4'h0 : wdt_cnt + {3'h0, wdt_run};
    end
endmodule // rsi_core_model

// ### tb/rsi_reset_init_asserts.sv
/*
 checker for the reset initial conditions block.
 assumes: sees only the top ports; bound after the module.
*/
`timescale 1ns/10ps
module rsi_chk
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic POR_REQ,
    input wire logic LOW_VOLTAGE_RESET,
    input wire logic WDT_TIMEOUT,
    input wire logic HALTED,
    input wire logic TIMEOUT_FLAG,
    input wire logic POWER_DOWN_FLAG,
    input wire logic PC_CLEAR,
    input wire logic SP_LOAD,
    input wire logic INT_DISABLE,
    input wire logic WDT_TB_CLEAR,
    input wire logic WDT_RUN,
    input wire logic TM_OFF,
    input wire logic IO_INPUT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // requests count only when taken out of reset with the clock enabled
    sequence s_por;
        $past(RST_N && CE && POR_REQ);
    endsequence
    sequence s_wdt;
        $past(RST_N && CE && WDT_TIMEOUT && !POR_REQ);
    endsequence
    a_por_flags: assert property (s_por |-> !TIMEOUT_FLAG && !POWER_DOWN_FLAG)
        else $error("flags not cleared");
    a_lvr_keeps: assert property ($past(RST_N && CE && LOW_VOLTAGE_RESET && !POR_REQ &&
        !HALTED) |-> $stable(TIMEOUT_FLAG) && $stable(POWER_DOWN_FLAG)) else $error("lvr moved");
    a_wdt_run: assert property (s_wdt ##0 $past(!HALTED && !LOW_VOLTAGE_RESET) |->
        TIMEOUT_FLAG && $stable(POWER_DOWN_FLAG)) else $error("wdt run flags");
    a_wdt_halt: assert property (s_wdt ##0 $past(HALTED) |->
        TIMEOUT_FLAG && POWER_DOWN_FLAG && PC_CLEAR && !INT_DISABLE) else $error("halt flags");
    a_int_off: assert property (s_por |-> INT_DISABLE) else $error("int on");
    a_wdt_clear: assert property (s_por |-> WDT_TB_CLEAR && WDT_RUN) else $error("wdt");
    a_timers_off: assert property (s_por |-> TM_OFF) else $error("timers");
    a_io_input: assert property (s_por |-> IO_INPUT) else $error("io dir");
    a_stack_top: assert property (s_por |-> SP_LOAD) else $error("stack");
    a_pulse_idle: assert property ($past(RST_N && CE && !POR_REQ && !LOW_VOLTAGE_RESET &&
        !WDT_TIMEOUT) |-> !PC_CLEAR && !SP_LOAD && !TM_OFF) else $error("pulse stuck");
    a_pc_zero: assert property (s_por |-> PC_CLEAR) else $error("pc not cleared");
    a_freeze_holds: assert property ($past(RST_N && !CE) |-> $stable(TIMEOUT_FLAG) &&
        $stable(POWER_DOWN_FLAG) && $stable(PC_CLEAR) && $stable(WDT_RUN))
        else $error("state moved while enable low");
endmodule // rsi_chk

bind rsi_reset_init rsi_chk u_chk (.CLK, .RST_N, .CE, .POR_REQ, .LOW_VOLTAGE_RESET,
    .WDT_TIMEOUT, .HALTED, .TIMEOUT_FLAG, .POWER_DOWN_FLAG, .PC_CLEAR, .SP_LOAD,
    .INT_DISABLE, .WDT_TB_CLEAR, .WDT_RUN, .TM_OFF, .IO_INPUT);

// ### tb/testbench.sv
/*
 self-checking bench for the reset initial conditions block.
 assumes: the design package and core model are compiled first.
*/
`timescale 1ns/10ps
module testbench;
    logic CLK, RST_N, CE, POR_REQ, LOW_VOLTAGE_RESET, WDT_TIMEOUT, HALTED;
    logic TIMEOUT_FLAG, POWER_DOWN_FLAG, PC_CLEAR, SP_LOAD, INT_DISABLE, WDT_TB_CLEAR;
    logic WDT_RUN, TM_OFF, IO_INPUT, ien;
    logic [12:0] PC_VALUE, pc;
    logic [2:0] SP_VALUE, TM_ENABLE_MASK, RESET_KIND, sp, tm;
    logic [28:0] IO_DIR_IN, dir;
    logic [3:0] wdt_cnt;
    int num_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    rsi_reset_init uut (.CLK, .RST_N, .CE, .POR_REQ, .LOW_VOLTAGE_RESET, .WDT_TIMEOUT,
        .HALTED, .TIMEOUT_FLAG, .POWER_DOWN_FLAG, .PC_CLEAR, .PC_VALUE, .SP_LOAD, .SP_VALUE,
        .INT_DISABLE, .WDT_TB_CLEAR, .WDT_RUN, .TM_OFF, .TM_ENABLE_MASK, .IO_INPUT,
        .IO_DIR_IN, .RESET_KIND);
    rsi_core_model core (.clk(CLK), .init({PC_CLEAR, SP_LOAD, INT_DISABLE, WDT_TB_CLEAR,
        TM_OFF, IO_INPUT}), .pc_val(PC_VALUE), .sp_val(SP_VALUE), .tm_val(TM_ENABLE_MASK),
        .dir_val(IO_DIR_IN), .wdt_run(WDT_RUN), .pc, .sp, .tm, .dir, .wdt_cnt, .ien);
    ////////////////////////////////////////
    task automatic results;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one request held for one taken edge: {por, lvr, wdt, halted}
    task automatic step(input logic [3:0] src, input logic [1:0] flg, input logic [2:0] knd);
        @(posedge CLK);
        {POR_REQ, LOW_VOLTAGE_RESET, WDT_TIMEOUT, HALTED} <= src;
        @(posedge CLK);
        {POR_REQ, LOW_VOLTAGE_RESET, WDT_TIMEOUT, HALTED} <= 4'h0;
        #1;
        chk({TIMEOUT_FLAG, POWER_DOWN_FLAG}, flg);
        chk(RESET_KIND, knd);
    endtask
    ////////////////////////////////////////
    // flag table walked in an order that shows both kept levels
    task automatic t_flags;
        step(4'h8, 2'h0, 3'h1);
        step(4'h2, 2'h2, 3'h3);
        step(4'h4, 2'h2, 3'h2);
        step(4'h3, 2'h3, 3'h4);
        step(4'h4, 2'h3, 3'h2);
        step(4'h2, 2'h3, 3'h3);
        step(4'h7, 2'h3, 3'h4);
        step(4'hE, 2'h0, 3'h1);
    endtask
    // power-on state seen at the core model, then the halted watchdog subset
    task automatic t_por_init;
        step(4'h8, 2'h0, 3'h1);
        chk({WDT_TB_CLEAR, WDT_RUN}, 2'h3);
        @(posedge CLK);
        #1;
        chk(pc, rsi_pkg::PC_RST);
        chk(sp, rsi_pkg::SP_TOP);
        chk(ien, 1'h0);
        chk(tm, rsi_pkg::TM_ALL_OFF);
        chk(dir, 29'h1FFFFFFF);
        chk({PC_CLEAR, INT_DISABLE, WDT_RUN}, 3'h1);
        chk(wdt_cnt, 4'h0);
        @(posedge CLK);
        #1;
        chk(wdt_cnt, 4'h1);
        step(4'h3, 2'h3, 3'h4);
        chk({PC_CLEAR, SP_LOAD, INT_DISABLE, TM_OFF}, 4'hC);
    endtask
    // a low enable freezes the block, so a power-on is not taken
    task automatic t_freeze;
        @(posedge CLK);
        CE <= 1'h0;
        step(4'h8, 2'h3, 3'h4);
        chk({PC_CLEAR, INT_DISABLE, WDT_TB_CLEAR}, 3'h0);
        @(posedge CLK);
        CE <= 1'h1;
    endtask
    // a reset in mid-run acts as a power-on: flags clear, pulses stand
    task automatic t_mid_reset;
        @(posedge CLK);
        RST_N <= 1'h0;
        repeat (2) @(posedge CLK);
        #1;
        chk({TIMEOUT_FLAG, POWER_DOWN_FLAG}, 2'h0);
        chk({PC_CLEAR, SP_LOAD, INT_DISABLE, WDT_TB_CLEAR, TM_OFF, IO_INPUT}, 6'h3F);
        chk({WDT_RUN, RESET_KIND}, 4'h9);
        @(posedge CLK);
        RST_N <= 1'h1;
        @(posedge CLK);
        #1;
        chk({PC_CLEAR, SP_LOAD, TM_OFF, IO_INPUT, WDT_RUN}, 5'h01);
    endtask
    ////////////////////////////////////////
    initial
    begin
        CLK = 1'h0;
        forever #12.5 CLK = ~CLK;
    end
    // hang guard: the run needs well under a hundred cycles
    always @(posedge CLK)
    begin
        cyc <= cyc + 1;
        if (cyc == 1000)
        begin
            num_errors++;
            results();
        end
    end
    initial
    begin
        {RST_N, CE, POR_REQ, LOW_VOLTAGE_RESET, WDT_TIMEOUT, HALTED} <= 6'h10;
        repeat (20) @(posedge CLK);
        RST_N <= 1'h1;
        t_flags();
        t_por_init();
        t_freeze();
        t_mid_reset();
        results();
    end
endmodule // testbench
